// ---- hw/edm_relay_sequencer.sv ----
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module edm_relay_sequencer import edm_pkg::*; #(
	parameter int CYC_MS = CYC_PER_MS
) (
	input wire logic clk, // system clock, 125 MHz
	input wire logic rst_n, // async reset, active low
	input wire logic signed [31:0] z_count, // raw Z encoder count
	input wire logic spark_pin, // spark detector, asynchronous
	output logic relay_retract, // 1 = energized (do not retract)
	output logic relay_dwell, // 1 = energized
	output logic relay_hold, // 1 = energized (at/below target)
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read valid
	input wire logic s_axi_rready // read ready
);
	typedef struct packed {
		seq_state_t st;
		logic en;
		logic [7:0] ctrl;
		logic [1:0] pview;
		logic signed [31:0] target;
		logic signed [31:0] rdist;
		logic signed [31:0] ztop;
		logic signed [31:0] revd;
		logic [31:0] dwell_ms;
		logic [31:0] spark_ms;
		logic signed [31:0] preset;
		logic signed [31:0] offset;
		logic signed [31:0] zmax;
		logic signed [31:0] ref_top;
		logic signed [31:0] zprev;
		logic signed [31:0] zlast;
		logic [31:0] tmr;
		logic [31:0] stall;
		logic [31:0] spk;
		logic [4:0] smp;
		logic hold;
		logic rev_flt;
		logic ret_flt;
		logic red;
		logic armed;
		logic spark_prev;
		logic r_ret;
		logic r_dwell;
		logic r_hold;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} seq_reg_t;

	seq_reg_t s, n;
	logic tick;
	logic spark;
	logic signed [31:0] zabs;
	logic view_ok;
	logic sample;
	logic spark_rise;
	logic cmd_tog;
	logic cmd_arm;
	logic cmd_clr;
	logic cmd_preset;
	logic retract_done;
	logic expired;

	ms_tick #(.CYC_MS(CYC_MS)) u_tick (
		.clk(clk),
		.rst_n(rst_n),
		.tick(tick)
	);

	pin_sync u_spark (
		.clk(clk),
		.rst_n(rst_n),
		.pin(spark_pin),
		.sync(spark)
	);

	// merge write data into a register under the byte enables
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = data[8*i +: 8];
			end
		end
		return r;
	endfunction : merge

	assign zabs = z_count - s.offset;

	always_comb begin
		n = s;
		cmd_tog = 1'b0;
		cmd_arm = 1'b0;
		cmd_clr = 1'b0;
		cmd_preset = 1'b0;
		retract_done = 1'b0;
		expired = 1'b0;
		spark_rise = spark && !s.spark_prev;
		n.spark_prev = spark;
		view_ok = (s.ctrl[B_VIEW +: 2] == VIEW_POS) ||
			(s.ctrl[B_VIEW +: 2] == VIEW_EDM);
		n.pview = s.ctrl[B_VIEW +: 2];
		sample = tick && (s.smp == 5'(T_SAMPLE_MS - 32'h1));

		// register bus: write side
		if (s_axi_awvalid && !s.aw_got && !s.bvalid) begin
			n.aw_got = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s.w_got && !s.bvalid) begin
			n.w_got = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (s.aw_got && s.w_got && !s.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			case (s.awaddr)
				A_CTRL: n.ctrl = s.wstrb[0] ? s.wdata[7:0] : s.ctrl;
				A_CMD: begin
					cmd_tog = s.wstrb[0] && s.wdata[C_TOGGLE];
					cmd_arm = s.wstrb[0] && s.wdata[C_ARM];
					cmd_clr = s.wstrb[0] && s.wdata[C_MISCLR];
					cmd_preset = s.wstrb[0] && s.wdata[C_PRESET];
				end
				A_TARGET: n.target = merge(s.target, s.wdata, s.wstrb);
				A_RDIST: n.rdist = merge(s.rdist, s.wdata, s.wstrb);
				A_ZTOP: n.ztop = merge(s.ztop, s.wdata, s.wstrb);
				A_REVD: n.revd = merge(s.revd, s.wdata, s.wstrb);
				A_DWELL: n.dwell_ms = merge(s.dwell_ms, s.wdata, s.wstrb);
				A_SPARK: n.spark_ms = merge(s.spark_ms, s.wdata, s.wstrb);
				A_PRESET: n.preset = merge(s.preset, s.wdata, s.wstrb);
				A_STATUS: begin
					// write one to clear; a fault in this cycle wins below
					if (s.wstrb[0] && s.wdata[S_REVF]) begin
						n.rev_flt = 1'b0;
					end
					if (s.wstrb[0] && s.wdata[S_RETF]) begin
						n.ret_flt = 1'b0;
					end
				end
				default: n.bresp = RESP_SLVERR;
			endcase
		end

		// register bus: read side
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !s.rvalid) begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			case (s_axi_araddr)
				A_CTRL: n.rdata = {24'h00_0000, s.ctrl};
				A_CMD: n.rdata = 32'h0000_0000;
				A_TARGET: n.rdata = s.target;
				A_RDIST: n.rdata = s.rdist;
				A_ZTOP: n.rdata = s.ztop;
				A_REVD: n.rdata = s.revd;
				A_DWELL: n.rdata = s.dwell_ms;
				A_SPARK: n.rdata = s.spark_ms;
				A_PRESET: n.rdata = s.preset;
				A_STATUS: n.rdata = {21'h00_0000, s.armed, s.en, s.r_hold,
					s.r_dwell, s.r_ret, s.red, s.ret_flt, s.rev_flt, s.st};
				A_ZABS: n.rdata = zabs;
				A_ZMAX: n.rdata = s.zmax;
				default: begin
					n.rdata = 32'h0000_0000;
					n.rresp = RESP_SLVERR;
				end
			endcase
		end

		// millisecond timebase
		if (tick) begin
			n.tmr = s.tmr + 32'h0000_0001;
			n.spk = s.spk + 32'h0000_0001;
			n.smp = sample ? 5'h00 : s.smp + 5'h01;
		end
		if (sample) begin
			n.zprev = zabs;
		end

		// datum handling
		if (cmd_arm) begin
			n.armed = 1'b1;
		end
		if (s.armed && spark_rise) begin
			n.offset = z_count;
			n.armed = 1'b0;
			n.zmax = 32'sh0000_0000;
		end
		if (cmd_preset) begin
			n.offset = z_count - s.preset;
			n.zmax = s.preset;
		end
		if (cmd_clr) begin
			n.zmax = zabs;
		end

		// enable toggle
		if (cmd_tog && view_ok) begin
			n.en = !s.en;
			if (!s.en) begin
				n.st = ST_READY;
				n.zmax = zabs;
				n.ref_top = zabs;
				n.tmr = '0;
				n.red = zabs > s.zprev;
			end else begin
				n.red = 1'b0;
			end
		end else if (s.en && view_ok && s.pview == VIEW_DATUM) begin
			n.st = ST_READY;
			n.zmax = zabs;
			n.ref_top = zabs;
			n.tmr = '0;
		end else if (s.en && view_ok) begin
			// sequencing runs only here: frozen in datum view
			// a datum or clear load in this cycle wins over tracking
			if (zabs < s.zmax && !cmd_preset && !cmd_clr &&
				!(s.armed && spark_rise)) begin
				n.zmax = zabs;
			end
			case (s.st)
				ST_READY: begin
					if (zabs > s.ref_top) begin
						n.ref_top = zabs;
					end
					if (zabs > s.target &&
						(s.ref_top - zabs) > DOWN_COUNTS) begin
						n.st = ST_BURN;
						n.zmax = zabs;
						n.red = 1'b0;
					end
				end
				ST_BURN: begin
					if (s.ctrl[B_REV_EN] && zabs > s.zmax + s.revd) begin
						n.st = ST_FAULT;
						n.rev_flt = 1'b1;
						n.tmr = '0;
					end else if (zabs <= s.target) begin
						n.tmr = '0;
						n.spk = '0;
						n.hold = 1'b0;
						if (s.ctrl[B_DWELL_EN] || s.ctrl[B_SPARK_EN]) begin
							n.st = ST_DWELL;
						end else begin
							n.st = ST_RETRACT;
							n.zlast = zabs;
							n.stall = '0;
						end
					end
				end
				ST_DWELL: begin
					if (sample) begin
						n.hold = zabs <= s.target;
					end
					if (spark) begin
						n.spk = '0;
					end
					expired = (s.ctrl[B_DWELL_EN] && s.tmr >= s.dwell_ms) ||
						(s.ctrl[B_SPARK_EN] && s.spk >= s.spark_ms);
					if (s.ctrl[B_REV_EN] && zabs > s.zmax + s.revd) begin
						n.st = ST_FAULT;
						n.rev_flt = 1'b1;
						n.tmr = '0;
						n.hold = 1'b0;
					end else if (expired) begin
						n.st = ST_DWELL_END;
						n.tmr = '0;
						n.hold = 1'b0;
					end
				end
				ST_DWELL_END: begin
					if (s.tmr >= T_DELAY_MS) begin
						n.st = ST_RETRACT;
						n.tmr = '0;
						n.zlast = zabs;
						n.stall = '0;
					end
				end
				ST_RETRACT: begin
					retract_done =
						(!s.ctrl[B_RDIST_EN] && !s.ctrl[B_ZTOP_EN]) ||
						(s.ctrl[B_RDIST_EN] && zabs >= s.target + s.rdist) ||
						(s.ctrl[B_ZTOP_EN] && zabs >= s.ztop);
					if (zabs != s.zlast) begin
						n.zlast = zabs;
						n.stall = '0;
					end else if (tick) begin
						n.stall = s.stall + 32'h0000_0001;
					end
					if (s.tmr >= T_DELAY_MS && retract_done) begin
						n.st = ST_READY;
						n.ref_top = zabs;
					end else if (s.stall >= T_STALL_MS) begin
						n.st = ST_READY;
						n.ret_flt = 1'b1;
						n.ref_top = zabs;
					end
				end
				ST_FAULT: begin
					if (s.tmr >= T_DELAY_MS) begin
						n.st = ST_READY;
						n.ref_top = zabs;
					end
				end
				default: n.st = ST_READY;
			endcase
		end

		// relay levels follow the next state
		n.r_ret = 1'b0;
		n.r_dwell = 1'b0;
		n.r_hold = 1'b0;
		if (n.en && ((n.ctrl[B_VIEW +: 2] == VIEW_POS) ||
			(n.ctrl[B_VIEW +: 2] == VIEW_EDM))) begin
			case (n.st)
				ST_READY, ST_BURN, ST_DWELL_END: n.r_ret = 1'b1;
				ST_DWELL: begin
					n.r_ret = 1'b1;
					n.r_dwell = 1'b1;
					n.r_hold = n.hold;
				end
				ST_RETRACT: n.r_dwell = 1'b1;
				default: n.r_ret = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.st <= ST_READY;
			s.en <= 1'b1;
			s.ctrl <= CTRL_RESET;
			s.r_ret <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign relay_retract = s.r_ret;
	assign relay_dwell = s.r_dwell;
	assign relay_hold = s.r_hold;
	assign s_axi_awready = !s.aw_got && !s.bvalid;
	assign s_axi_wready = !s.w_got && !s.bvalid;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rdata = s.rdata;
endmodule : edm_relay_sequencer
`default_nettype wire

// ---- hw/edm_pkg.sv ----
// What this block does
// - Relays are driven only when enabled and the view is position or discharge.
// - After power-up retract is energized, dwell and position hold de-energized.
// - Sequencing is frozen while the datum-set or preset view is open.
// - Leaving the datum view restarts sequencing in Ready for a new burn.
// - Max depth reloads on enable, burn start, datum set/preset, miscount clear.
// - Spark-probe mode zeroes the datum at the first detected spark.
// - With the function disabled all three relays stay inactive.
// - Each enable/disable command toggles the function, in position or discharge view.
// - Ready is entered on enable and at the end of every Retract.
// - Ready: retract on, dwell and hold off, max tracks, reverse ignored.
// - Ready goes to Burn when above target and moved down over 20 counts.
// - Burn: retract on, dwell and hold off, max tracks, reverse checked if enabled.
// - Target reached in Burn: Dwell if dwell or spark-out enabled, else Retract.
// - Dwell samples Z every 20 ms; hold on at or below target, else off.
// - Dwell: retract and dwell on, max tracks, reverse checked if enabled.
// - Dwell or spark-out expiry drops dwell and hold, waits 100 ms, then Retract.
// - Retract: retract off at least 100 ms, hold off, dwell on, stall checked.
// - Retract ends on retract distance, top position, or neither setting enabled.
// - Reverse creep over set distance above max depth flags fault, drops retract.
// - A reverse fault holds retract at its retract level for 0.1 s.
// - No ram motion for one second in Retract flags a fault and goes Ready.
// - Enabling while Z moves upward raises the red not-started indication.
package edm_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int T_MS_NS = 1000000;
	localparam int CYC_PER_MS = T_MS_NS / CLK_PERIOD_NS;
	localparam logic [31:0] T_SAMPLE_MS = 32'h0000_0014; // 20 ms
	localparam logic [31:0] T_DELAY_MS = 32'h0000_0064; // 100 ms
	localparam logic [31:0] T_STALL_MS = 32'h0000_03e8; // 1000 ms
	localparam logic signed [31:0] DOWN_COUNTS = 32'sh0000_0014; // 20
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_CMD = 8'h04;
	localparam logic [7:0] A_TARGET = 8'h08;
	localparam logic [7:0] A_RDIST = 8'h0c;
	localparam logic [7:0] A_ZTOP = 8'h10;
	localparam logic [7:0] A_REVD = 8'h14;
	localparam logic [7:0] A_DWELL = 8'h18;
	localparam logic [7:0] A_SPARK = 8'h1c;
	localparam logic [7:0] A_PRESET = 8'h20;
	localparam logic [7:0] A_STATUS = 8'h24;
	localparam logic [7:0] A_ZABS = 8'h28;
	localparam logic [7:0] A_ZMAX = 8'h2c;
	localparam int B_REV_EN = 0;
	localparam int B_DWELL_EN = 1;
	localparam int B_SPARK_EN = 2;
	localparam int B_RDIST_EN = 3;
	localparam int B_ZTOP_EN = 4;
	localparam int B_VIEW = 5;
	localparam int C_TOGGLE = 0;
	localparam int C_ARM = 1;
	localparam int C_MISCLR = 2;
	localparam int C_PRESET = 3;
	localparam int S_REVF = 3;
	localparam int S_RETF = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] VIEW_POS = 2'h0;
	localparam logic [1:0] VIEW_EDM = 2'h1;
	localparam logic [1:0] VIEW_DATUM = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		ST_READY = 3'h0,
		ST_BURN = 3'h1,
		ST_DWELL = 3'h2,
		ST_DWELL_END = 3'h3,
		ST_RETRACT = 3'h4,
		ST_FAULT = 3'h5
	} seq_state_t;
endpackage : edm_pkg

// ---- hw/pin_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module pin_sync import edm_pkg::*; (
	input wire logic clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic pin, // asynchronous input
	output logic sync // synchronised level
);
	typedef struct packed {
		logic meta;
		logic sync;
	} sync_reg_t;
	sync_reg_t s, n;
	always_comb begin
		n.meta = pin;
		n.sync = s.meta;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
	assign sync = s.sync;
endmodule : pin_sync
`default_nettype wire

// ---- hw/ms_tick.sv ----
`timescale 1ns/1ns
`default_nettype none
module ms_tick import edm_pkg::*; #(
	parameter int CYC_MS = CYC_PER_MS
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // async reset, active low
	output logic tick // one-cycle pulse each millisecond
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} tick_reg_t;
	tick_reg_t s, n;
	always_comb begin
		n = s;
		n.tick = 1'b0;
		if (s.cnt >= 32'(CYC_MS - 1)) begin
			n.cnt = '0;
			n.tick = 1'b1;
		end else begin
			n.cnt = s.cnt + 32'h0000_0001;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
	assign tick = s.tick;
endmodule : ms_tick
`default_nettype wire

// ---- tb/seq_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module seq_chk import edm_pkg::*; #(
	parameter int CYC_MS = CYC_PER_MS
) (
	input wire logic clk, // clock
	input wire logic rst_n, // reset
	input wire logic relay_retract, // retract relay
	input wire logic relay_dwell, // dwell relay
	input wire logic relay_hold, // hold relay
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic s_axi_rvalid // r valid
);
	logic [31:0] low_q;
	// length of the current retract-released stretch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			low_q <= '0;
		else if (relay_retract)
			low_q <= '0;
		else
			low_q <= low_q + 32'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_hold_in_dwell: assert property (
		relay_hold |-> relay_dwell && relay_retract)
		else $error("hold relay outside dwell");
	a_retract_min: assert property (
		$rose(relay_retract) && $past(relay_dwell) |-> low_q >= 98 * CYC_MS)
		else $error("retract released too briefly");
	a_dwell_end: assert property (
		$fell(relay_dwell) && relay_retract |-> relay_retract [*8])
		else $error("retract dropped right after dwell end");
	a_retract_entry: assert property (
		$rose(relay_dwell) && !relay_retract |-> $past(relay_retract)
		&& !relay_hold)
		else $error("retract entry relays wrong");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while answer pending");
	a_aw_block: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_r_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_b_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
endmodule : seq_chk
bind edm_relay_sequencer seq_chk #(.CYC_MS(CYC_MS)) chk_u (.clk(clk),
	.rst_n(rst_n), .relay_retract(relay_retract), .relay_dwell(relay_dwell),
	.relay_hold(relay_hold), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid));
`default_nettype wire

// ---- tb/ram_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module ram_model (
	input wire logic clk, // clock
	input wire logic rst_n, // reset
	input wire logic relay_retract, // retract relay
	input wire logic relay_dwell, // dwell relay
	input wire logic relay_hold, // hold relay
	input wire logic [1:0] mode, // 0 follow, 1 stalled, 2 creeping up
	output logic signed [31:0] z_count, // encoder count
	output logic spark_pin // gap spark
);
	logic [1:0] div_q;
	// one count every four cycles: down while burning, up on retract
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= '0;
			z_count <= '0;
		end else begin
			div_q <= div_q + 2'h1;
			if (div_q == 2'h3 && mode == 2'h2)
				z_count <= z_count + 32'sh1;
			else if (div_q == 2'h3 && mode == 2'h0) begin
				if (!relay_retract)
					z_count <= z_count + 32'sh1;
				else if (!relay_hold)
					z_count <= z_count - 32'sh1;
			end
		end
	end
	assign spark_pin = relay_retract && !relay_dwell && mode == 2'h0;
endmodule : ram_model
`default_nettype wire

// ---- tb/edm_relay_sequencer_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module edm_relay_sequencer_test import edm_pkg::*;;
	localparam int CYC = 10;
	logic clk, rst_n, spark_pin, ret, dwl, hld;
	logic signed [31:0] z_count;
	logic [1:0] mode, bresp, rresp, rsp;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rdat, za;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	int n_fail, n_compared;
	edm_relay_sequencer #(.CYC_MS(CYC)) dut_u (.clk(clk), .rst_n(rst_n),
		.z_count(z_count), .spark_pin(spark_pin), .relay_retract(ret),
		.relay_dwell(dwl), .relay_hold(hld), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	ram_model ram_u (.clk(clk), .rst_n(rst_n), .relay_retract(ret),
		.relay_dwell(dwl), .relay_hold(hld), .mode(mode),
		.z_count(z_count), .spark_pin(spark_pin));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic complete_run();
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	task automatic hang(input string m);
		n_fail++;
		$display("wrong value at %0t: %s timed out", $time, m);
		complete_run();
	endtask : hang
	task automatic cw(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s %h not %h", $time, m, got, exp);
		end
	endtask : cw
	task automatic cr(input logic [2:0] exp, input string m);
		cw({29'h0, ret, dwl, hld}, {29'h0, exp}, m);
	endtask : cr
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
		end
		rsp = bresp;
		if (i == 100) hang("write");
	endtask : wr
	task automatic rd(input logic [7:0] a);
		int i;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
		end
		rdat = rdata;
		rsp = rresp;
		if (i == 100) hang("read");
	endtask : rd
	task automatic ws(input logic [2:0] st, input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			rd(A_STATUS);
			if (rdat[2:0] === st) break;
		end
		if (i == lim) hang("state wait");
	endtask : ws
	task automatic test_end(input string m);
		$display("test %s ended, mismatches so far %0d", m, n_fail);
	endtask : test_end
	initial begin
		n_fail = 0;
		n_compared = 0;
		rst_n = 1'b0;
		mode = 2'h1;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		cr(3'b100, "reset relays");
		rd(A_STATUS);
		cw(rdat & 32'h207, 32'h200, "reset status");
		rd(8'h40);
		cw(rdat, 32'h0, "unmapped read data");
		cw({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped read resp");
		wr(8'h40, 32'h1);
		cw({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped write resp");
		rd(A_CMD);
		cw(rdat, 32'h0, "command reads zero");
		test_end("reset");
		wr(A_TARGET, 32'hffff_ffc4);
		wr(A_RDIST, 32'h28);
		wr(A_DWELL, 32'h1e);
		wr(A_CTRL, 32'h0a);
		mode <= 2'h0;
		ws(3'h1, 200);
		cr(3'b100, "burn relays");
		ws(3'h2, 200);
		repeat (25 * CYC) @(posedge clk);
		cr(3'b111, "dwell relays");
		ws(3'h3, 200);
		cr(3'b100, "dwell end relays");
		ws(3'h4, 1000);
		cr(3'b010, "retract relays");
		ws(3'h0, 1000);
		cr(3'b100, "ready after retract");
		test_end("cycle");
		mode <= 2'h1;
		wr(A_CMD, 32'h1);
		rd(A_STATUS);
		cw(rdat & 32'h200, 32'h0, "disabled");
		cr(3'b000, "disabled relays");
		wr(A_CMD, 32'h1);
		rd(A_STATUS);
		cw(rdat & 32'h207, 32'h200, "re-enabled ready");
		wr(A_CTRL, 32'h4a);
		wr(A_CMD, 32'h1);
		rd(A_STATUS);
		cw(rdat & 32'h200, 32'h200, "toggle refused in datum");
		cr(3'b000, "datum view relays");
		wr(A_CTRL, 32'h0a);
		rd(A_ZABS);
		za = rdat;
		rd(A_ZMAX);
		cw(rdat, za, "max depth reloaded");
		rd(A_STATUS);
		cw(rdat & 32'h7, 32'h0, "ready after datum");
		cr(3'b100, "relays after datum");
		test_end("toggle and view");
		wr(A_REVD, 32'h5);
		wr(A_CTRL, 32'h0b);
		mode <= 2'h0;
		ws(3'h1, 200);
		mode <= 2'h2;
		ws(3'h5, 200);
		cr(3'b000, "reverse fault pulse");
		mode <= 2'h1;
		ws(3'h0, 1000);
		cw(rdat & 32'h18, 32'h08, "reverse fault flag");
		wr(A_STATUS, 32'h08);
		test_end("reverse");
		wr(A_CTRL, 32'h0a);
		mode <= 2'h0;
		ws(3'h4, 1000);
		mode <= 2'h1;
		ws(3'h0, 6000);
		cw(rdat & 32'h18, 32'h10, "retract fault flag");
		wr(A_STATUS, 32'h18);
		rd(A_STATUS);
		cw(rdat & 32'h18, 32'h0, "fault flags cleared");
		test_end("stall");
		wr(A_CMD, 32'h2);
		rd(A_STATUS);
		cw(rdat & 32'h400, 32'h400, "probe armed");
		mode <= 2'h0;
		repeat (8) @(posedge clk);
		mode <= 2'h1;
		rd(A_STATUS);
		cw(rdat & 32'h400, 32'h0, "probe fired");
		rd(A_ZABS);
		cw({31'h0, rdat >= 32'hffff_fffd || rdat == 0}, 32'h1, "zeroed");
		wr(A_PRESET, 32'h64);
		wr(A_CMD, 32'h8);
		rd(A_ZABS);
		cw(rdat, 32'h64, "preset position");
		rd(A_ZMAX);
		cw(rdat, 32'h64, "max after preset");
		test_end("probe and preset");
		complete_run();
	end
endmodule : edm_relay_sequencer_test
`default_nettype wire
